// [indicator_blink_breathe_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1 - Invert bit 7 of pattern register flips the indicator pin level.
// R2 - Bit 6 selects pattern: 0 blink, 1 breathe.
// R3 - Blink period is rate bits 5:0 times 50 ms, on half the period.
// R4 - Blink rate spans 50 ms up to 3.15 s.
// R5 - In breathe mode the rate field gives breath length in 500 ms units.
// R6 - Blink keeps going for trail time (bits 7:2, 50 ms) after run clears.
// R7 - In breathe mode bits 7:2 give sleep between breaths in 500 ms units.
// R8 - Setting the run bit (bit 1) starts the selected pattern.
// R9 - Pattern timer starts when run is set; no shortened pulses.
// R10 - Breathe stops at once when run clears.
// R11 - Bit 0 selects plain I/O (0) or indicator pattern (1).
// R12 - In indicator mode the plain output data bit is ignored.
// R13 - In indicator mode the plain input readback is not valid.
// R14 - A prescaler makes the 50 ms and 500 ms time units.
// R15 - A breath ramps brightness up then down by PWM, peak mid-breath.
module indicator_blink_breathe_ctl #(
	parameter int HALF_UNIT_CYCLES_P   = indicator_pkg::HALF_UNIT_CYCLES,
	parameter int BREATH_STEP_CYCLES_P = indicator_pkg::BREATH_STEP_CYCLES
) (
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic [15:0] cfg_addr_in,
	input  wire logic        cfg_write_in,
	input  wire logic [7:0]  cfg_wdata_in,
	input  wire logic        cfg_read_in,
	output logic [7:0]       cfg_rdata_out,
	output logic             cfg_rvalid_out,
	input  wire logic        indicator_out_a_in,
	output logic             indicator_out_a_out,
	output logic             indicator_out_a_oe_out,
	input  wire logic        plain_io_a_data_in,
	input  wire logic        plain_io_a_dir_in,
	output logic             plain_io_a_read_out,
	input  wire logic        indicator_out_b_in,
	output logic             indicator_out_b_out,
	output logic             indicator_out_b_oe_out,
	input  wire logic        plain_io_b_data_in,
	input  wire logic        plain_io_b_dir_in,
	output logic             plain_io_b_read_out
);
	import indicator_pkg::*;

	// Returns channel index and register select for a mapped address
	function automatic logic [2:0] decode_addr(input logic [15:0] addr);
		case (addr)
			ADDR_IND0_PATTERN: decode_addr = 3'b100;
			ADDR_IND0_RUN:     decode_addr = 3'b101;
			ADDR_IND1_PATTERN: decode_addr = 3'b110;
			ADDR_IND1_RUN:     decode_addr = 3'b111;
			default:           decode_addr = 3'b000;
		endcase
	endfunction : decode_addr

	function automatic logic [10:0] to_halves(input logic [5:0] field, input logic mode);
		if (mode == MODE_BREATHE) begin
			to_halves = 11'(field * HALVES_PER_BREATH);
		end else begin
			to_halves = 11'(field * HALVES_PER_BLINK);
		end
	endfunction : to_halves

	logic [7:0] pattern_ctl_reg [NUM_CHANNELS];
	logic [7:0] pattern_ctl_next [NUM_CHANNELS];
	logic [7:0] run_ctl_reg [NUM_CHANNELS];
	logic [7:0] run_ctl_next [NUM_CHANNELS];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       rvalid_reg;
	logic       rvalid_next;
	logic [2:0] hit;

	logic [NUM_CHANNELS-1:0] pin_in_w;
	logic [NUM_CHANNELS-1:0] plain_data_w;
	logic [NUM_CHANNELS-1:0] plain_dir_w;
	logic [NUM_CHANNELS-1:0] pin_out_reg;
	logic [NUM_CHANNELS-1:0] pin_oe_reg;
	logic [NUM_CHANNELS-1:0] read_reg;

	assign pin_in_w     = {indicator_out_b_in, indicator_out_a_in};
	assign plain_data_w = {plain_io_b_data_in, plain_io_a_data_in};
	assign plain_dir_w  = {plain_io_b_dir_in, plain_io_a_dir_in};

	always_comb begin
		hit         = decode_addr(cfg_addr_in);
		rdata_next  = rdata_reg;
		rvalid_next = cfg_read_in;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			pattern_ctl_next[i] = pattern_ctl_reg[i];
			run_ctl_next[i]     = run_ctl_reg[i];
		end
		if (cfg_write_in && hit[2]) begin
			if (hit[0]) begin
				run_ctl_next[hit[1]] = cfg_wdata_in;
			end else begin
				pattern_ctl_next[hit[1]] = cfg_wdata_in;
			end
		end
		if (cfg_read_in) begin
			if (!hit[2]) begin
				rdata_next = 8'h00;
			end else if (hit[0]) begin
				rdata_next = run_ctl_reg[hit[1]];
			end else begin
				rdata_next = pattern_ctl_reg[hit[1]];
			end
		end
	end

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				pattern_ctl_reg[i] <= CTL_RESET;
				run_ctl_reg[i]     <= CTL_RESET;
			end
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				pattern_ctl_reg[i] <= pattern_ctl_next[i];
				run_ctl_reg[i]     <= run_ctl_next[i];
			end
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign cfg_rdata_out  = rdata_reg;
	assign cfg_rvalid_out = rvalid_reg;

	for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : chan
		indicator_chan_if link ();

		half_unit_ticker #(
			.CYCLES (HALF_UNIT_CYCLES_P)
		) u_ticker (
			.clock_in (clock_in),
			.reset_in (reset_in),
			.tb       (link.ticker)
		);

		level_dimmer u_dimmer (
			.clock_in (clock_in),
			.reset_in (reset_in),
			.dm       (link.dimmer)
		);

		chan_state_t state_reg;
		chan_state_t state_next;
		logic        run_prev_reg;
		logic        run_prev_next;
		logic        phase_on_reg;
		logic        phase_on_next;
		logic [10:0] phase_cnt_reg;
		logic [10:0] phase_cnt_next;
		logic [10:0] trail_cnt_reg;
		logic [10:0] trail_cnt_next;
		logic [31:0] step_cnt_reg;
		logic [31:0] step_cnt_next;
		logic [7:0]  level_reg;
		logic [7:0]  level_next;
		logic        falling_reg;
		logic        falling_next;
		logic        pattern_w;
		logic        invert;
		logic        mode;
		logic        run;
		logic        func;
		logic [5:0]  rate;
		logic [5:0]  trail;
		logic [31:0] step_limit;

		always_comb begin
			invert     = pattern_ctl_reg[ch][INVERT_BIT];
			mode       = pattern_ctl_reg[ch][MODE_BIT]; // R2
			rate       = pattern_ctl_reg[ch][RATE_MSB:RATE_LSB];
			trail      = run_ctl_reg[ch][TRAIL_MSB:TRAIL_LSB];
			run        = run_ctl_reg[ch][RUN_BIT];
			func       = run_ctl_reg[ch][FUNC_BIT];
			step_limit = 32'(rate * BREATH_STEP_CYCLES_P); // R5
			state_next     = state_reg;
			run_prev_next  = run;
			phase_on_next  = phase_on_reg;
			phase_cnt_next = phase_cnt_reg;
			trail_cnt_next = trail_cnt_reg;
			step_cnt_next  = step_cnt_reg;
			level_next     = level_reg;
			falling_next   = falling_reg;
			link.restart   = 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (func && run && !run_prev_reg) begin
						link.restart   = 1'b1; // R9
						state_next     = ST_RUN; // R8
						phase_on_next  = 1'b1;
						phase_cnt_next = 11'h0;
						trail_cnt_next = 11'h0;
						step_cnt_next  = 32'h0;
						level_next     = 8'h00;
						falling_next   = 1'b0;
					end
				end
				ST_RUN, ST_TRAIL: begin
					if (mode == MODE_BLINK) begin
						if (link.tick_half) begin
							// One half-unit per phase step gives the 50 % duty
							if (phase_cnt_reg + 11'h1 >= 11'(rate)) begin // R3 R4
								phase_cnt_next = 11'h0;
								phase_on_next  = !phase_on_reg;
							end else begin
								phase_cnt_next = phase_cnt_reg + 11'h1;
							end
							if (state_reg == ST_TRAIL) begin
								trail_cnt_next = trail_cnt_reg + 11'h1; // R14
							end
						end
						if (state_reg == ST_RUN && !run) begin
							state_next     = ST_TRAIL; // R6
							trail_cnt_next = 11'h0;
						end else if (state_reg == ST_TRAIL && run) begin
							state_next = ST_RUN;
						end else if (state_reg == ST_TRAIL && !phase_on_reg
							&& trail_cnt_reg >= to_halves(trail, mode)) begin
							state_next = ST_IDLE; // R6 R9
						end
					end else if (!run) begin
						state_next = ST_IDLE; // R10
						level_next = 8'h00;
					end else begin
						if (step_cnt_reg + 32'h1 >= step_limit) begin
							step_cnt_next = 32'h0;
							if (!falling_reg) begin
								level_next = level_reg + 8'h01; // R15
								if (level_reg == LEVEL_MAX - 8'h01) begin
									falling_next = 1'b1;
								end
							end else if (level_reg != 8'h00) begin
								level_next = level_reg - 8'h01; // R15
							end else begin
								state_next     = ST_SLEEP; // R7
								phase_cnt_next = 11'h0;
								falling_next   = 1'b0;
							end
						end else begin
							step_cnt_next = step_cnt_reg + 32'h1;
						end
					end
				end
				ST_SLEEP: begin
					if (!run) begin
						state_next = ST_IDLE; // R10
					end else if (phase_cnt_reg >= to_halves(trail, mode)) begin
						state_next    = ST_RUN; // R7
						step_cnt_next = 32'h0;
						level_next    = 8'h00;
					end else if (link.tick_half) begin
						phase_cnt_next = phase_cnt_reg + 11'h1; // R14
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
			if (!func) begin
				state_next = ST_IDLE; // R11
				level_next = 8'h00;
			end
			link.level = level_reg;
			if (mode == MODE_BREATHE) begin
				pattern_w = (state_reg == ST_RUN) && link.pwm;
			end else begin
				pattern_w = (state_reg == ST_RUN || state_reg == ST_TRAIL)
					&& phase_on_reg && (rate != 6'h00);
			end
		end

		always_ff @(posedge clock_in or posedge reset_in) begin
			if (reset_in) begin
				state_reg     <= ST_IDLE;
				run_prev_reg  <= 1'b0;
				phase_on_reg  <= 1'b0;
				phase_cnt_reg <= 11'h0;
				trail_cnt_reg <= 11'h0;
				step_cnt_reg  <= 32'h0;
				level_reg     <= 8'h00;
				falling_reg   <= 1'b0;
				pin_out_reg[ch] <= 1'b0;
				pin_oe_reg[ch]  <= 1'b0;
				read_reg[ch]    <= 1'b0;
			end else begin
				state_reg     <= state_next;
				run_prev_reg  <= run_prev_next;
				phase_on_reg  <= phase_on_next;
				phase_cnt_reg <= phase_cnt_next;
				trail_cnt_reg <= trail_cnt_next;
				step_cnt_reg  <= step_cnt_next;
				level_reg     <= level_next;
				falling_reg   <= falling_next;
				pin_out_reg[ch] <= func ? (pattern_w ^ invert) : plain_data_w[ch]; // R1 R11 R12
				pin_oe_reg[ch]  <= func | plain_dir_w[ch]; // R11
				read_reg[ch]    <= func ? 1'b0 : pin_in_w[ch]; // R13
			end
		end
	end

	assign indicator_out_a_out    = pin_out_reg[0];
	assign indicator_out_a_oe_out = pin_oe_reg[0];
	assign plain_io_a_read_out    = read_reg[0];
	assign indicator_out_b_out    = pin_out_reg[1];
	assign indicator_out_b_oe_out = pin_oe_reg[1];
	assign plain_io_b_read_out    = read_reg[1];
endmodule : indicator_blink_breathe_ctl
`default_nettype wire

// [indicator_pkg.sv]
`default_nettype none
package indicator_pkg;
	localparam logic [15:0] ADDR_IND0_PATTERN = 16'h0806;
	localparam logic [15:0] ADDR_IND0_RUN     = 16'h0807;
	localparam logic [15:0] ADDR_IND1_PATTERN = 16'h0808;
	localparam logic [15:0] ADDR_IND1_RUN     = 16'h0809;
	localparam int NUM_CHANNELS  = 2;
	localparam int INVERT_BIT    = 7;
	localparam int MODE_BIT      = 6;
	localparam int RATE_MSB      = 5;
	localparam int RATE_LSB      = 0;
	localparam int TRAIL_MSB     = 7;
	localparam int TRAIL_LSB     = 2;
	localparam int RUN_BIT       = 1;
	localparam int FUNC_BIT      = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic MODE_BLINK  = 1'b0;
	localparam logic MODE_BREATHE = 1'b1;
	localparam longint CLK_PERIOD_NS = 40;
	// Half of the 50 ms blink unit, so a 50 % duty cycle is exact
	localparam longint BLINK_UNIT_NS     = 50_000_000;
	localparam longint BREATH_UNIT_NS    = 500_000_000;
	localparam int     HALF_UNIT_CYCLES  = int'(BLINK_UNIT_NS / 2 / CLK_PERIOD_NS);
	localparam int     HALVES_PER_BLINK  = 2;
	localparam int     HALVES_PER_BREATH = int'(2 * BREATH_UNIT_NS / BLINK_UNIT_NS);
	localparam int     BREATH_STEPS      = 512;
	localparam int     BREATH_STEP_CYCLES = int'(BREATH_UNIT_NS / CLK_PERIOD_NS / BREATH_STEPS);
	localparam logic [7:0] LEVEL_MAX     = 8'hff;
	typedef enum {ST_IDLE, ST_RUN, ST_TRAIL, ST_SLEEP} chan_state_t;
endpackage : indicator_pkg
`default_nettype wire

// [indicator_chan_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface indicator_chan_if;
	logic       restart;
	logic       tick_half;
	logic [7:0] level;
	logic       pwm;
	modport ticker (input restart, output tick_half);
	modport tick_user (output restart, input tick_half);
	modport dimmer (input level, output pwm);
	modport dim_user (output level, input pwm);
endinterface : indicator_chan_if
`default_nettype wire

// [half_unit_ticker.sv]
`timescale 1ns/100ps
`default_nettype none
module half_unit_ticker #(
	parameter int CYCLES = indicator_pkg::HALF_UNIT_CYCLES
) (
	input  wire logic         clock_in,
	input  wire logic         reset_in,
	indicator_chan_if.ticker  tb
);
	import indicator_pkg::*;

	logic [31:0] count_reg;
	logic [31:0] count_next;

	// Restart realigns the timebase so a pattern starts at the set moment
	always_comb begin
		tb.tick_half = 1'b0;
		count_next   = count_reg + 32'h1;
		if (tb.restart) begin
			count_next = 32'h0;
		end else if (count_reg >= 32'(CYCLES - 1)) begin
			count_next   = 32'h0;
			tb.tick_half = 1'b1; // R14
		end
	end

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			count_reg <= 32'h0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule : half_unit_ticker
`default_nettype wire

// [level_dimmer.sv]
`timescale 1ns/100ps
`default_nettype none
module level_dimmer (
	input  wire logic         clock_in,
	input  wire logic         reset_in,
	indicator_chan_if.dimmer  dm
);
	import indicator_pkg::*;

	logic [7:0] sweep_reg;
	logic [7:0] sweep_next;
	logic       pwm_reg;
	logic       pwm_next;

	always_comb begin
		sweep_next = sweep_reg + 8'h01;
		pwm_next   = (dm.level == LEVEL_MAX) || (dm.level > sweep_reg);
	end

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			sweep_reg <= 8'h00;
			pwm_reg   <= 1'b0;
		end else begin
			sweep_reg <= sweep_next;
			pwm_reg   <= pwm_next;
		end
	end

	assign dm.pwm = pwm_reg;
endmodule : level_dimmer
`default_nettype wire

// [indicator_load.sv]
`timescale 1ns/100ps
`default_nettype none
module indicator_load (
	input  wire logic drive_in,
	input  wire logic oe_in,
	input  wire logic ext_in,
	input  wire logic ext_en_in,
	output logic      level_out
);
	// Pull-down holds a released pin low
	assign level_out = oe_in ? drive_in : (ext_en_in ? ext_in : 1'b0);
endmodule : indicator_load
`default_nettype wire

// [indicator_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module indicator_checker
	import indicator_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        reset_in,
	input wire logic [15:0] cfg_addr_in,
	input wire logic        cfg_write_in,
	input wire logic [7:0]  cfg_wdata_in,
	input wire logic        cfg_read_in,
	input wire logic [7:0]  cfg_rdata_out,
	input wire logic        cfg_rvalid_out,
	input wire logic        indicator_out_a_in,
	input wire logic        indicator_out_a_out,
	input wire logic        indicator_out_a_oe_out,
	input wire logic        plain_io_a_data_in,
	input wire logic        plain_io_a_dir_in,
	input wire logic        plain_io_a_read_out,
	input wire logic        indicator_out_b_in,
	input wire logic        indicator_out_b_out,
	input wire logic        indicator_out_b_oe_out,
	input wire logic        plain_io_b_data_in,
	input wire logic        plain_io_b_dir_in,
	input wire logic        plain_io_b_read_out
);
	import indicator_pkg::*;
	logic [7:0] ctl_reg [4];
	logic [7:0] ctl_next [4];
	logic [1:0] idx;
	logic       hit;
	logic [7:0] rd_sel;
	logic       func_a, func_b, oe_a, oe_b, rb_a, rb_b;
	// Shadow of the control registers, kept from the bus traffic
	assign idx = 2'(cfg_addr_in - ADDR_IND0_PATTERN);
	assign hit = cfg_addr_in >= ADDR_IND0_PATTERN && cfg_addr_in <= ADDR_IND1_RUN;
	assign rd_sel = hit ? ctl_reg[idx] : 8'h00;
	assign func_a = ctl_reg[1][FUNC_BIT];
	assign func_b = ctl_reg[3][FUNC_BIT];
	assign oe_a = func_a | plain_io_a_dir_in;
	assign oe_b = func_b | plain_io_b_dir_in;
	assign rb_a = func_a ? 1'b0 : indicator_out_a_in;
	assign rb_b = func_b ? 1'b0 : indicator_out_b_in;
	always_comb begin
		ctl_next = ctl_reg;
		if (cfg_write_in && hit) ctl_next[idx] = cfg_wdata_in;
	end
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) ctl_reg <= '{default: CTL_RESET};
		else ctl_reg <= ctl_next;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	a_rvalid_pulse: assert property (1'b1 |=> cfg_rvalid_out == $past(cfg_read_in))
		else $error("read valid pulse wrong");
	a_read_data: assert property (cfg_read_in |=> cfg_rdata_out == $past(rd_sel))
		else $error("read data wrong");
	a_plain_drive_a: assert property (!func_a |=> indicator_out_a_out == $past(plain_io_a_data_in))
		else $error("plain drive a wrong");
	a_enable_a: assert property (1'b1 |=> indicator_out_a_oe_out == $past(oe_a))
		else $error("enable a wrong");
	a_readback_a: assert property (1'b1 |=> plain_io_a_read_out == $past(rb_a))
		else $error("readback a wrong");
	a_plain_drive_b: assert property (!func_b |=> indicator_out_b_out == $past(plain_io_b_data_in))
		else $error("plain drive b wrong");
	a_enable_b: assert property (1'b1 |=> indicator_out_b_oe_out == $past(oe_b))
		else $error("enable b wrong");
	a_readback_b: assert property (1'b1 |=> plain_io_b_read_out == $past(rb_b))
		else $error("readback b wrong");
	c_read_hit: cover property (cfg_read_in && hit);
	c_blink_a: cover property (func_a && $rose(indicator_out_a_out));
	c_blink_b: cover property (func_b && $fell(indicator_out_b_out));
endmodule : indicator_checker
bind indicator_blink_breathe_ctl indicator_checker i_chk (
	.clock_in, .reset_in, .cfg_addr_in, .cfg_write_in, .cfg_wdata_in, .cfg_read_in,
	.cfg_rdata_out, .cfg_rvalid_out, .indicator_out_a_in, .indicator_out_a_out,
	.indicator_out_a_oe_out, .plain_io_a_data_in, .plain_io_a_dir_in, .plain_io_a_read_out,
	.indicator_out_b_in, .indicator_out_b_out, .indicator_out_b_oe_out,
	.plain_io_b_data_in, .plain_io_b_dir_in, .plain_io_b_read_out
);
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	import indicator_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        dat_a = 1'b0, dir_a = 1'b0, dat_b = 1'b0, dir_b = 1'b0;
	logic        ext = 1'b0, ext_en = 1'b0;
	logic [7:0]  rdata;
	logic        rvalid, pin_a, pin_b, out_a, out_b, oe_a, oe_b, rb_a, rb_b;
	logic [1:0]  drv;
	int          mismatches = 0, n_tests = 0, cyc = 0, n;
	int          lo, hi, sl, nx;
	// Pin levels taken mid-cycle, where they are settled
	always @(negedge clk) drv <= {out_b, out_a};
	always #20 clk = ~clk;
	indicator_blink_breathe_ctl #(.HALF_UNIT_CYCLES_P(10), .BREATH_STEP_CYCLES_P(2)) i_dut (
		.clock_in(clk), .reset_in(rst), .cfg_addr_in(addr), .cfg_write_in(wr_en),
		.cfg_wdata_in(wdata), .cfg_read_in(rd_en), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
		.indicator_out_a_in(pin_a), .indicator_out_a_out(out_a), .indicator_out_a_oe_out(oe_a),
		.plain_io_a_data_in(dat_a), .plain_io_a_dir_in(dir_a), .plain_io_a_read_out(rb_a),
		.indicator_out_b_in(pin_b), .indicator_out_b_out(out_b), .indicator_out_b_oe_out(oe_b),
		.plain_io_b_data_in(dat_b), .plain_io_b_dir_in(dir_b), .plain_io_b_read_out(rb_b));
	indicator_load i_load_a (.drive_in(out_a), .oe_in(oe_a), .ext_in(ext), .ext_en_in(ext_en), .level_out(pin_a));
	indicator_load i_load_b (.drive_in(out_b), .oe_in(oe_b), .ext_in(ext), .ext_en_in(ext_en), .level_out(pin_b));
	task automatic conclude;
		if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic chkb(input logic seen, input logic exp);
		chk({15'h0, seen}, {15'h0, exp});
	endtask : chkb
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chkb(rvalid, 1'b1);
		chk({8'h00, rdata}, {8'h00, e});
		@(posedge clk);
	endtask : rdc
	// Length of the next run at level lvl, after waiting for it to begin
	task automatic span(input int ch, input logic lvl, output int len);
		int w;
		w = 0;
		len = 0;
		while (drv[ch] !== lvl && w < 2000) begin
			@(posedge clk);
			w++;
		end
		while (drv[ch] === lvl && len < 2000) begin
			@(posedge clk);
			len++;
		end
	endtask : span
	task automatic quiet(input int ch, output int hits);
		hits = 0;
		repeat (100) begin
			@(posedge clk);
			if (drv[ch] !== 1'b0) hits++;
		end
	endtask : quiet
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) rdc(16'h0805 + 16'(i), 8'h00);
		wr(ADDR_IND0_PATTERN, 8'ha5);
		wr(ADDR_IND1_PATTERN, 8'h5a);
		wr(ADDR_IND0_RUN, 8'hfc);
		wr(16'h080a, 8'hff);
		rdc(ADDR_IND0_PATTERN, 8'ha5);
		rdc(ADDR_IND1_PATTERN, 8'h5a);
		rdc(ADDR_IND0_RUN, 8'hfc);
		rdc(16'h080a, 8'h00);
		wr(ADDR_IND0_PATTERN, 8'h00);
		wr(ADDR_IND0_RUN, 8'h00);
		dat_a <= 1'b1;
		dir_a <= 1'b1;
		dat_b <= 1'b1;
		dir_b <= 1'b1;
		repeat (3) @(posedge clk);
		chkb(out_a, 1'b1);
		chkb(out_b, 1'b1);
		dir_a <= 1'b0;
		ext_en <= 1'b1;
		ext <= 1'b1;
		repeat (3) @(posedge clk);
		chkb(oe_a, 1'b0);
		chkb(rb_a, 1'b1);
		wr(ADDR_IND0_RUN, 8'h01);
		repeat (3) @(posedge clk);
		chkb(oe_a, 1'b1);
		chkb(out_a, 1'b0);
		chkb(rb_a, 1'b0);
		ext_en <= 1'b0;
		dat_b <= 1'b0;
		wr(ADDR_IND0_PATTERN, 8'h80);
		repeat (3) @(posedge clk);
		chkb(out_a, 1'b1);
		wr(ADDR_IND0_PATTERN, 8'h02);
		wr(ADDR_IND0_RUN, 8'h07);
		span(0, 1'b1, n);
		chk(16'(n), 16'd20);
		span(0, 1'b0, n);
		chk(16'(n), 16'd20);
		span(0, 1'b1, n);
		chk(16'(n), 16'd20);
		wr(ADDR_IND0_RUN, 8'h0d);
		span(0, 1'b1, n);
		chk(16'(n), 16'd20);
		repeat (200) @(posedge clk);
		quiet(0, n);
		chk(16'(n), 16'd0);
		wr(ADDR_IND1_PATTERN, 8'h3f);
		wr(ADDR_IND1_RUN, 8'h03);
		span(1, 1'b1, n);
		chk(16'(n), 16'd630);
		wr(ADDR_IND1_RUN, 8'h01);
		wr(ADDR_IND0_PATTERN, 8'h41);
		wr(ADDR_IND0_RUN, 8'h07);
		// Dim at the start of a breath, bright around its middle, dark while asleep
		lo = 0;
		hi = 0;
		sl = 0;
		nx = 0;
		for (int i = 0; i < 1656; i++) begin
			@(posedge clk);
			if (drv[0] === 1'b1) begin
				if (i < 128) lo++;
				else if (i >= 448 && i < 576) hi++;
				else if (i >= 1060 && i < 1200) sl++;
				else if (i >= 1400) nx++;
			end
		end
		chkb(lo < 80, 1'b1);
		chkb(hi > 80, 1'b1);
		chk(16'(sl), 16'd0);
		chkb(nx > 0, 1'b1);
		wr(ADDR_IND0_RUN, 8'h01);
		@(posedge clk);
		quiet(0, n);
		chk(16'(n), 16'd0);
		conclude();
	end
endmodule : tb
`default_nettype wire
